// ### logic/chs_slave.sv
`timescale 1ns/1ps
module chs_slave
    import chs_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [15:0] MAKER_CODE = 16'h00a5,
    parameter logic [15:0] PART_CODE  = 16'h005a
)
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // Bus pins
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_oe_n,
    // Analog-side setpoints
    output logic [CUR_DAC_W-1:0]       current_dac_code,
    output logic [VOLT_DAC_W-1:0]      voltage_dac_code,
    output logic                       charge_enable
);
    logic        scl_s;
    logic        sda_s;
    logic        scl_d_r;
    logic        sda_d_r;
    chs_state_t  state_r;
    chs_state_t  state_nxt;
    logic [3:0]  bit_r;
    logic [7:0]  shift_r;
    logic [1:0]  slot_r;
    logic [7:0]  cmd_r;
    logic [7:0]  low_r;
    logic [15:0] rdata_r;
    logic        rd_high_r;
    logic [15:0] cur_word_r;
    logic [15:0] volt_word_r;
    logic        cur_set_r;
    logic        volt_set_r;

    // Pins cross into the clock domain first
    chs_sync u_sync_scl
    (
        .clock (clock),
        .reset (reset),
        .din   (scl_in),
        .dout  (scl_s)
    );
    chs_sync u_sync_sda
    (
        .clock (clock),
        .reset (reset),
        .din   (sda_in),
        .dout  (sda_s)
    );

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Edge and condition detection
    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire [7:0] byte_in  = {shift_r[6:0], sda_s};
    wire       last_bit = (bit_r == BIT_LAST);
    wire       ack_bit  = (bit_r == BIT_ACK);
    wire       addr_hit = (byte_in[7:1] == SLAVE_ADDR);
    wire       is_read  = byte_in[0];
    // Only the four command codes are claimed
    function automatic logic cmd_valid(input logic [7:0] code);
        return (code == CMD_CURRENT) | (code == CMD_VOLTAGE)
             | (code == CMD_MAKER_ID) | (code == CMD_PART_ID);
    endfunction
    wire cmd_known = cmd_valid(byte_in);
    wire cmd_held  = cmd_valid(cmd_r);
    wire cmd_is_id = (cmd_r == CMD_MAKER_ID) | (cmd_r == CMD_PART_ID);
    // Fixed words; nothing can write them
    wire [15:0] id_word = (cmd_r == CMD_PART_ID) ? PART_CODE
                                                 : MAKER_CODE;
    wire write_done = (state_r == ST_WRITE) & scl_rise & last_bit
                    & (slot_r == SLOT_LOW);

    // Byte-level protocol state
    always_comb
    begin
        state_nxt = state_r;
        if (stop_det)
            state_nxt = ST_IDLE;
        else if (start_det)
            state_nxt = ST_ADDR;
        else if (scl_rise & last_bit)
        begin
            unique case (state_r)
                ST_IDLE:  state_nxt = ST_IDLE;
                ST_ADDR:
                begin
                    // Read only allowed after a known id command
                    if (!addr_hit)
                        state_nxt = ST_IDLE;
                    else if (is_read & ~(cmd_is_id & slot_r == SLOT_CMD))
                        state_nxt = ST_IDLE;
                    else if (is_read)
                        state_nxt = ST_READ;
                    else
                        state_nxt = ST_WRITE;
                end
                ST_WRITE:
                begin
                    // Command is the first byte after the address
                    if (slot_r == 2'h0 & !cmd_known)
                        state_nxt = ST_IDLE;
                end
                ST_READ:  state_nxt = ST_RACK;
                ST_RACK:  state_nxt = ST_RACK;
            endcase
        end
        else if (scl_rise & ack_bit & state_r == ST_RACK)
        begin
            // Master NACK or second byte ends the read
            if (sda_s | rd_high_r)
                state_nxt = ST_IDLE;
            else
                state_nxt = ST_READ;
        end
    end

    // Bit counter: 0..7 data, 8 ack
    always_ff @(posedge clock)
    begin
        if (reset)
            bit_r <= 4'h0;
        // START's own clock fall then wraps the count to bit 0
        else if (start_det)
            bit_r <= BIT_ACK;
        else if (scl_fall & state_r != ST_IDLE)
            bit_r <= ack_bit ? 4'h0 : bit_r + 4'h1;
    end

    // Shift in on clock rise, MSB first
    always_ff @(posedge clock)
    begin
        if (reset)
            shift_r <= 8'h00;
        else if (scl_rise & ~bit_r[3])
            shift_r <= byte_in;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Slot counts data bytes; cleared at STOP or an unmatched address, so restart keeps cmd
    always_ff @(posedge clock)
    begin
        if (reset | stop_det)
            slot_r <= 2'h0;
        else if (scl_rise & last_bit & state_r == ST_WRITE)
            slot_r <= slot_r + 2'h1;
        else if (scl_rise & last_bit & state_r == ST_ADDR & ~addr_hit)
            slot_r <= 2'h0;
    end

    // Capture command and low data byte
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cmd_r <= 8'h00;
            low_r <= 8'h00;
        end
        else if (scl_rise & last_bit & state_r == ST_WRITE)
        begin
            if (slot_r == 2'h0)
                cmd_r <= byte_in;
            if (slot_r == SLOT_CMD)
                low_r <= byte_in;
        end
    end

    // Setpoints; write-only, cleared at reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cur_word_r  <= SETPOINT_RST;
            volt_word_r <= SETPOINT_RST;
            cur_set_r   <= 1'b0;
            volt_set_r  <= 1'b0;
        end
        else if (write_done)
        begin
            if (cmd_r == CMD_CURRENT)
            begin
                cur_word_r <= {byte_in, low_r};
                cur_set_r  <= 1'b1;
            end
            if (cmd_r == CMD_VOLTAGE)
            begin
                volt_word_r <= {byte_in, low_r};
                volt_set_r  <= 1'b1;
            end
        end
    end

    // DAC codes take only the weighted fields
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            current_dac_code <= '0;
            voltage_dac_code <= '0;
            charge_enable    <= 1'b0;
        end
        else
        begin
            current_dac_code <=
                cur_word_r[CUR_DAC_LSB +: CUR_DAC_W];
            voltage_dac_code <=
                volt_word_r[VOLT_DAC_LSB +: VOLT_DAC_W];
            charge_enable    <= cur_set_r & volt_set_r;
        end
    end

    // Read data: low byte first, then high
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rdata_r   <= 16'h0000;
            rd_high_r <= 1'b0;
        end
        else if (state_r == ST_ADDR & state_nxt == ST_READ)
        begin
            rdata_r   <= id_word;
            rd_high_r <= 1'b0;
        end
        else if (state_r == ST_RACK & state_nxt == ST_READ)
        begin
            rdata_r   <= {8'h00, rdata_r[15:8]};
            rd_high_r <= 1'b1;
        end
    end

    // Data line drive, updated on clock fall (low phase); released at START or STOP
    // Eighth fall: state has already left ADDR, so ack from WRITE or READ
    wire ack_slot = (state_r == ST_WRITE | state_r == ST_READ)
                  & (bit_r == BIT_LAST);
    // Latched command decides; the shifter already holds later bits
    wire ack_go   = ack_slot
                  & ~(state_r == ST_WRITE & slot_r == SLOT_CMD & !cmd_held);
    wire [2:0] rd_idx = 3'(BIT_LAST - (ack_bit ? 4'h0 : bit_r + 4'h1));
    wire       rd_bit = (ack_bit | state_r == ST_ADDR)
                        ? rdata_r[7] : rdata_r[rd_idx];
    // Only the data line is driven; the clock is never touched
    always_ff @(posedge clock)
    begin
        if (reset | start_det | stop_det)
            sda_oe_n <= 1'b1;
        else if (scl_fall)
        begin
            if (ack_go)
                sda_oe_n <= 1'b0;
            else if (state_r == ST_READ & ~last_bit)
                sda_oe_n <= rd_bit;
            else
                sda_oe_n <= 1'b1;
        end
    end

    // Assertions share the system clock and sleep during reset
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);

    // Eighth clock fall of an address byte that was taken
    sequence s_addr_ack_slot;
        scl_fall && bit_r == BIT_LAST
        && (state_r == ST_READ || (state_r == ST_WRITE && slot_r == 2'h0));
    endsequence

    a_oe_stable_high: assert property
        (scl_s & scl_d_r & ~start_det & ~stop_det |=> $stable(sda_oe_n))
        else $error("data drive changed while clock high");
    a_start_resets: assert property
        (start_det & ~stop_det |=> state_r == ST_ADDR && bit_r == BIT_ACK)
        else $error("start did not reset receive state");
    a_stop_idle: assert property
        (stop_det |=> state_r == ST_IDLE && sda_oe_n)
        else $error("stop did not return to idle");
    a_idle_no_drive: assert property
        (state_r == ST_IDLE && $past(state_r) == ST_IDLE |-> sda_oe_n)
        else $error("data driven while idle");
    a_addr_acked: assert property
        (s_addr_ack_slot |=> !sda_oe_n)
        else $error("matched address not acknowledged");
    a_cur_field: assert property
        (1'b1 |=> current_dac_code == $past(cur_word_r[10:5]))
        else $error("current code wrong field");
    a_volt_field: assert property
        (1'b1 |=> voltage_dac_code == $past(volt_word_r[14:4]))
        else $error("voltage code wrong field");
    a_enable_gate: assert property
        (charge_enable |-> cur_set_r && volt_set_r)
        else $error("charging enabled before both setpoints");
    a_cur_load: assert property
        (write_done && cmd_r == CMD_CURRENT |=> cur_word_r[15:8] ==
         $past(byte_in) && cur_set_r)
        else $error("current setpoint not loaded");
    a_id_fixed: assert property
        (state_r == ST_ADDR && state_nxt == ST_READ && cmd_r == CMD_PART_ID
         |=> rdata_r == PART_CODE)
        else $error("part code not loaded for read");
    a_volt_keep: assert property
        (!write_done |=> $stable(volt_word_r))
        else $error("voltage setpoint changed without write");
endmodule // chs_slave

// ### logic/chs_pkg.sv
package chs_pkg;
    // Bus address and command codes
    localparam logic [6:0] SLAVE_ADDR     = 7'h09;
    localparam logic [7:0] CMD_CURRENT    = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE    = 8'h15;
    localparam logic [7:0] CMD_MAKER_ID   = 8'hfe;
    localparam logic [7:0] CMD_PART_ID    = 8'hff;
    // Setpoint reset value, DAC field layout and bit counter marks
    localparam logic [15:0] SETPOINT_RST  = 16'h0000;
    localparam int          CUR_DAC_LSB   = 5;
    localparam int          CUR_DAC_W     = 6;
    localparam int          VOLT_DAC_LSB  = 4;
    localparam int          VOLT_DAC_W    = 11;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    // Byte slot within a transaction
    localparam logic [1:0]  SLOT_CMD      = 2'h1;
    localparam logic [1:0]  SLOT_LOW      = 2'h2;
    localparam logic [1:0]  SLOT_HIGH     = 2'h3;
    // Protocol states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b011,
        ST_RACK  = 3'b100
    } chs_state_t;
endpackage

// ### logic/chs_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a pin level
module chs_sync
    import chs_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;

    // First flop feeds only the second
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta_r <= 1'b1;
            dout   <= 1'b1;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // chs_sync

// ### dv/chs_host_model.sv
`timescale 1ns/1ps
// Bus master stand-in; both wires idle high (pull-ups) between frames
module chs_host_model
(
    // System clock
    input  wire logic clock,
    // Bus wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_o
);
    initial
    begin
        scl   = 1'b1;
        sda_o = 1'b1;
    end

    // Step on falling edges so the DUT never sees a race
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Data moves only in the low phase, sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        tick(3);
        sda_o = b;
        tick(1);
        scl = 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl = 1'b0;
    endtask

    // START or repeated START
    task automatic start();
        tick(3);
        sda_o = 1'b1;
        tick(1);
        scl = 1'b1;
        tick(4);
        sda_o = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    // STOP, then the bus is free
    task automatic stop();
        tick(3);
        sda_o = 1'b0;
        tick(1);
        scl = 1'b1;
        tick(4);
        sda_o = 1'b1;
        tick(4);
    endtask

    // Eight bits MSB first, then the ninth acknowledge clock
    task automatic byte_x(input logic [7:0] d, input logic a_in,
                          output logic [7:0] q, output logic a_out);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(a_in, a_out);
    endtask
endmodule // chs_host_model

// ### dv/charger_smbus_command_slave_test.sv
`timescale 1ns/1ps
module charger_smbus_command_slave_test;
    import chs_pkg::*;
    // Arbitrary identification values, not the defaults
    localparam logic [15:0] MAKER = 16'h00c3;
    localparam logic [15:0] PART  = 16'h003c;
    logic                  clock;
    logic                  reset;
    logic                  scl;
    logic                  sda_o;
    wire logic             sda;
    logic                  sda_oe_n;
    logic [CUR_DAC_W-1:0]  cur;
    logic [VOLT_DAC_W-1:0] volt;
    logic                  en;
    int                    errors;
    int                    n_tests;

    // Open-drain wire: either party may pull low
    assign sda = sda_o & sda_oe_n;

    chs_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_o(sda_o));

    chs_slave #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
        .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_oe_n(sda_oe_n), .current_dac_code(cur),
        .voltage_dac_code(volt), .charge_enable(en));

    initial
        clock = 1'b0;
    always #5 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Word write; acks[3] is the address slot
    task automatic wr_word(input logic [6:0] a, input logic [7:0] c,
                           input logic [15:0] d, output logic [3:0] k);
        logic [7:0] q;
        host.start();
        host.byte_x({a, 1'b0}, 1'b1, q, k[3]);
        host.byte_x(c, 1'b1, q, k[2]);
        host.byte_x(d[7:0], 1'b1, q, k[1]);
        host.byte_x(d[15:8], 1'b1, q, k[0]);
        host.stop();
    endtask

    // Word read with repeated START; master NACKs the high byte
    task automatic rd_word(input logic [7:0] c, output logic [15:0] d,
                           output logic [2:0] k);
        logic [7:0] q;
        logic       x;
        host.start();
        host.byte_x({SLAVE_ADDR, 1'b0}, 1'b1, q, k[2]);
        host.byte_x(c, 1'b1, q, k[1]);
        host.start();
        host.byte_x({SLAVE_ADDR, 1'b1}, 1'b1, q, k[0]);
        host.byte_x(8'hff, 1'b0, d[7:0], x);
        host.byte_x(8'hff, 1'b1, d[15:8], x);
        host.stop();
    endtask

    task automatic t_reset();
        chk({10'h0, cur}, 16'h0000);
        chk({5'h0, volt}, 16'h0000);
        chk({15'h0, en}, 16'h0000);
        chk({15'h0, sda_oe_n}, 16'h0001);
    endtask

    // Ignored bits only, then DAC bits only
    task automatic t_current();
        logic [3:0] k;
        wr_word(SLAVE_ADDR, CMD_CURRENT, 16'hf81f, k);
        chk({12'h0, k}, 16'h0000);
        chk({10'h0, cur}, 16'h0000);
        wr_word(SLAVE_ADDR, CMD_CURRENT, 16'h07e0, k);
        chk({10'h0, cur}, 16'h003f);
        chk({15'h0, en}, 16'h0000);
    endtask

    task automatic t_voltage();
        logic [3:0] k;
        wr_word(SLAVE_ADDR, CMD_VOLTAGE, 16'h8ab5, k);
        chk({12'h0, k}, 16'h0000);
        chk({5'h0, volt}, 16'h00ab);
        chk({15'h0, en}, 16'h0001);
    endtask

    // Identification words, each read twice
    task automatic t_ids();
        logic [15:0] d;
        logic [2:0]  k;
        logic [7:0]  c [2] = '{CMD_MAKER_ID, CMD_PART_ID};
        logic [15:0] e [2] = '{MAKER, PART};
        for (int r = 0; r < 4; r++)
        begin
            rd_word(c[r % 2], d, k);
            chk({13'h0, k}, 16'h0000);
            chk(d, e[r % 2]);
        end
    endtask

    // Wrong address, unknown command, read of write-only, id write
    task automatic t_refuse();
        logic [3:0]  k;
        logic [2:0]  j;
        logic [15:0] d;
        wr_word(7'h0a, CMD_CURRENT, 16'h0000, k);
        chk({12'h0, k}, 16'h000f);
        chk({10'h0, cur}, 16'h003f);
        wr_word(SLAVE_ADDR, 8'h33, 16'h0000, k);
        chk({12'h0, k}, 16'h0007);
        rd_word(CMD_CURRENT, d, j);
        chk({13'h0, j}, 16'h0001);
        chk(d, 16'hffff);
        wr_word(SLAVE_ADDR, CMD_PART_ID, 16'h1234, k);
        chk({12'h0, k}, 16'h0000);
        rd_word(CMD_PART_ID, d, j);
        chk(d, PART);
        chk({10'h0, cur}, 16'h003f);
    endtask

    initial
    begin
        errors  = 0;
        n_tests = 0;
        reset   = 1'b1;
        host.tick(2);
        reset = 1'b0;
        host.tick(4);
        t_reset();
        t_current();
        t_voltage();
        t_ids();
        t_refuse();
        end_sim();
    end

    // Watchdog well beyond the few thousand cycles the tests need
    initial
    begin
        #200000;
        errors++;
        end_sim();
    end
endmodule // charger_smbus_command_slave_test
